// ---- hw/dopwm_consts.svh ----
// Register offsets, field positions and reset values of the dual PWM unit
`ifndef DOPWM_CONSTS_SVH
`define DOPWM_CONSTS_SVH

// Register indices; byte address on the bus is four times the index
`define DOPWM_IDX_A_EXTRA 16'h7FAA
`define DOPWM_IDX_A_DUTY 16'h7FAB
`define DOPWM_IDX_B_EXTRA 16'h7FAC
`define DOPWM_IDX_B_DUTY 16'h7FAD
`define DOPWM_IDX_CTRL 16'h7FAE
`define DOPWM_IDX_PRESCALE 16'h7FAF
`define DOPWM_IDX_TMCLK 16'h7FB6
`define DOPWM_IDX_PORT_FSA 16'h7FC0
`define DOPWM_IDX_PORT_FSB 16'h7FC1
`define DOPWM_IDX_PORT_LAT 16'h7FC2
`define DOPWM_IDX_PORT_DDR 16'h7FC3

// Reset values
`define DOPWM_RST_BYTE 8'h00
`define DOPWM_RST_NIB 4'h0

// Control register fields
`define DOPWM_CTRL_PERIOD_MSB 7
`define DOPWM_CTRL_PERIOD_LSB 4
`define DOPWM_CTRL_B_RUN 3
`define DOPWM_CTRL_A_RUN 2
`define DOPWM_CTRL_FLAG 1
`define DOPWM_CTRL_IRQ_EN 0

// Clock select field of the timer clock setting register
`define DOPWM_TMCLK_SEL 0

// Port bits that carry the two outputs
`define DOPWM_PIN_A 6
`define DOPWM_PIN_B 7

// Counter figures
`define DOPWM_FUND_LOW_NIB 4'hF
`define DOPWM_LAST_PERIOD 4'hF

`endif

// ---- hw/dopwm_pkg.sv ----
// Types shared by the dual PWM unit
package dopwm_pkg;

	// How a port pin is driven from its four select bits
	typedef enum logic [2:0] {
		DOPWM_PIN_INV,
		DOPWM_PIN_CMOS,
		DOPWM_PIN_SLOW,
		DOPWM_PIN_OD,
		DOPWM_PIN_PORT
	} dopwm_pin_mode_t;

endpackage : dopwm_pkg

// ---- hw/dopwm_chan.sv ----
// One PWM output channel: compare buffer, extra pulse choice, waveform
`timescale 1ns/1ps
`include "dopwm_consts.svh"

module dopwm_chan import dopwm_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Shared timebase
	input wire logic run,
	input wire logic reload,
	input wire logic [7:0] fund_cnt,
	input wire logic [3:0] add_cnt,
	// Software settings
	input wire logic [7:0] duty_high,
	input wire logic [3:0] extra,
	// Waveform
	output logic pwm
);

	logic [7:0] buf_r;
	logic [3:0] ext_r;
	logic [3:0] rev;
	logic [8:0] width;
	logic add_now;

	// Buffers follow the registers when stopped, reload at count zero
	always_ff @(posedge clk) begin
		if (rst) begin
			buf_r <= `DOPWM_RST_BYTE;
			ext_r <= `DOPWM_RST_NIB;
		end else if (!run || reload) begin
			buf_r <= duty_high;
			ext_r <= extra;
		end
	end

	// Bit reversal spreads extra periods evenly; count equals the value
	assign rev = {add_cnt[0], add_cnt[1], add_cnt[2], add_cnt[3]};
	assign add_now = (rev < ext_r);
	// Twelve bit duty: buffer is the high byte, one step more when chosen
	assign width = {1'b0, buf_r} + {8'h00, add_now};

	// High while the count is below the width; low from the match on
	always_ff @(posedge clk) begin
		if (rst) begin
			pwm <= 1'b0;
		end else begin
			pwm <= run && ({1'b0, fund_cnt} < width);
		end
	end

endmodule : dopwm_chan

// ---- hw/dopwm_top.sv ----
// Dual output 12-bit PWM unit with its Avalon-MM register slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`include "dopwm_consts.svh"

// Summary of operation
// - Extra pulse registers keep bits 7..4 only; low nibble reads zero.
// - Output A high width is A duty byte times one prescaler period.
// - Output B high width is B duty byte times one prescaler period.
// - A extra nibble zero gives plain 8-bit PWM on output A.
// - B extra nibble zero gives plain 8-bit PWM on output B.
// - Prescaler period is prescale count plus one, in selected clocks.
// - Clock select bit 0: zero system clock, one oscillator clock.
// - Upper seven clock setting bits have no effect on this unit.
// - Overall period is sixteen fundamental periods shared by both.
// - Extra nibble picks which of sixteen periods get one added step.
// - Duty byte and extra nibble form one twelve bit duty setting.
// - Fundamental period is period field plus one, times sixteen.
// - Pin 6 select combinations give inverted, CMOS, slow or drain A.
// - Pin 7 same combinations give the four drive kinds for B.
// - Each output runs on its enable, low otherwise; counters stop both off.
// - Output drops at buffer match; buffer reloads at count zero.
// - Overflow flag set per overall period, software clears, gated request.
module dopwm_top import dopwm_pkg::*; (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Avalon-MM slave, byte addressed
	input wire logic [17:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	// Oscillator clock from its pin
	input wire logic OSC_CLOCK,
	// Port pin 6 carrying output A
	output logic PORT_PIN_6_OUT,
	output logic PORT_PIN_6_OE_N,
	output logic PORT_PIN_6_SLOW,
	// Port pin 7 carrying output B
	output logic PORT_PIN_7_OUT,
	output logic PORT_PIN_7_OE_N,
	output logic PORT_PIN_7_SLOW,
	// Interrupt request level
	output logic IRQ_REQ
);

	////////////////////////////////////////////////////////////////////////
	// Register state

	logic [3:0] a_extra_r;
	logic [7:0] a_duty_r;
	logic [3:0] b_extra_r;
	logic [7:0] b_duty_r;
	logic [3:0] period_r;
	logic a_run_r;
	logic b_run_r;
	logic period_flag_r;
	logic irq_en_r;
	logic [7:0] prescale_r;
	logic [7:0] tmclk_r;
	logic [7:0] fsa_r;
	logic [7:0] fsb_r;
	logic [7:0] lat_r;
	logic [7:0] ddr_r;

	////////////////////////////////////////////////////////////////////////
	// Bus slave

	logic [15:0] idx;
	logic req;
	logic wr_go;
	logic lane0;
	logic [7:0] wbyte;
	logic [7:0] rd_nxt;
	logic overall_end;

	assign idx = AVS_ADDRESS[17:2];
	assign req = AVS_READ || AVS_WRITE;
	// Write lands on the edge where waitrequest is seen low
	assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;
	assign lane0 = AVS_BYTEENABLE[0];
	assign wbyte = AVS_WRITEDATA[7:0];

	// One wait cycle lets read data settle in a flop before it is taken
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			AVS_WAITREQUEST <= 1'b1;
		end else if (req && AVS_WAITREQUEST) begin
			AVS_WAITREQUEST <= 1'b0;
		end else begin
			AVS_WAITREQUEST <= 1'b1;
		end
	end

	// Read mux; unmapped indices and unused upper bits read zero
	always_comb begin
		rd_nxt = `DOPWM_RST_BYTE;
		unique case (idx)
			`DOPWM_IDX_A_EXTRA: rd_nxt = {a_extra_r, 4'h0};
			`DOPWM_IDX_A_DUTY: rd_nxt = a_duty_r;
			`DOPWM_IDX_B_EXTRA: rd_nxt = {b_extra_r, 4'h0};
			`DOPWM_IDX_B_DUTY: rd_nxt = b_duty_r;
			`DOPWM_IDX_CTRL: rd_nxt = {period_r, b_run_r, a_run_r,
				period_flag_r, irq_en_r};
			`DOPWM_IDX_PRESCALE: rd_nxt = prescale_r;
			`DOPWM_IDX_TMCLK: rd_nxt = tmclk_r;
			`DOPWM_IDX_PORT_FSA: rd_nxt = fsa_r;
			`DOPWM_IDX_PORT_FSB: rd_nxt = fsb_r;
			`DOPWM_IDX_PORT_LAT: rd_nxt = lat_r;
			`DOPWM_IDX_PORT_DDR: rd_nxt = ddr_r;
			default: rd_nxt = `DOPWM_RST_BYTE;
		endcase
	end

	// Read data captured during the wait cycle
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			AVS_READDATA <= 32'h00000000;
		end else if (AVS_READ && AVS_WAITREQUEST) begin
			AVS_READDATA <= {24'h000000, rd_nxt};
		end
	end

	// Plain storage registers; only the upper nibble of extras is kept
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			a_extra_r <= `DOPWM_RST_NIB;
			a_duty_r <= `DOPWM_RST_BYTE;
			b_extra_r <= `DOPWM_RST_NIB;
			b_duty_r <= `DOPWM_RST_BYTE;
			prescale_r <= `DOPWM_RST_BYTE;
			tmclk_r <= `DOPWM_RST_BYTE;
			fsa_r <= `DOPWM_RST_BYTE;
			fsb_r <= `DOPWM_RST_BYTE;
			lat_r <= `DOPWM_RST_BYTE;
			ddr_r <= `DOPWM_RST_BYTE;
		end else if (wr_go && lane0) begin
			unique case (idx)
				`DOPWM_IDX_A_EXTRA: a_extra_r <= wbyte[7:4];
				`DOPWM_IDX_A_DUTY: a_duty_r <= wbyte;
				`DOPWM_IDX_B_EXTRA: b_extra_r <= wbyte[7:4];
				`DOPWM_IDX_B_DUTY: b_duty_r <= wbyte;
				`DOPWM_IDX_PRESCALE: prescale_r <= wbyte;
				`DOPWM_IDX_TMCLK: tmclk_r <= wbyte;
				`DOPWM_IDX_PORT_FSA: fsa_r <= wbyte;
				`DOPWM_IDX_PORT_FSB: fsb_r <= wbyte;
				`DOPWM_IDX_PORT_LAT: lat_r <= wbyte;
				`DOPWM_IDX_PORT_DDR: ddr_r <= wbyte;
				default: ;
			endcase
		end
	end

	// Control fields written as a group
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			period_r <= `DOPWM_RST_NIB;
			a_run_r <= 1'b0;
			b_run_r <= 1'b0;
			irq_en_r <= 1'b0;
		end else if (wr_go && lane0 && idx == `DOPWM_IDX_CTRL) begin
			period_r <= wbyte[`DOPWM_CTRL_PERIOD_MSB:`DOPWM_CTRL_PERIOD_LSB];
			b_run_r <= wbyte[`DOPWM_CTRL_B_RUN];
			a_run_r <= wbyte[`DOPWM_CTRL_A_RUN];
			irq_en_r <= wbyte[`DOPWM_CTRL_IRQ_EN];
		end
	end

	// Overflow flag: writing zero clears it, a period end in that cycle wins
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			period_flag_r <= 1'b0;
		end else if (overall_end) begin
			period_flag_r <= 1'b1;
		end else if (wr_go && lane0 && idx == `DOPWM_IDX_CTRL &&
			!wbyte[`DOPWM_CTRL_FLAG]) begin
			period_flag_r <= 1'b0;
		end
	end

	// Request level follows flag and enable
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			IRQ_REQ <= 1'b0;
		end else begin
			IRQ_REQ <= period_flag_r && irq_en_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillator clock sampling

	logic osc_s1_r;
	logic osc_s2_r;
	logic osc_s3_r;
	logic osc_tick;

	// Two flops before use; the third only serves the edge detector
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
		end else begin
			osc_s1_r <= OSC_CLOCK;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
		end
	end

	// Oscillator must run below half the system rate to be seen
	assign osc_tick = osc_s2_r && !osc_s3_r;

	////////////////////////////////////////////////////////////////////////
	// Shared timebase

	logic any_run;
	logic cnt_clk;
	logic [7:0] pre_cnt_r;
	logic pre_match;
	logic [7:0] fund_cnt_r;
	logic fund_match;
	logic [3:0] add_cnt_r;

	assign any_run = a_run_r || b_run_r;
	// Only bit 0 of the clock setting register matters here
	assign cnt_clk = tmclk_r[`DOPWM_TMCLK_SEL] ? osc_tick : 1'b1;
	assign pre_match = cnt_clk && (pre_cnt_r == prescale_r);
	assign fund_match = pre_match &&
		(fund_cnt_r == {period_r, `DOPWM_FUND_LOW_NIB});
	assign overall_end = fund_match &&
		(add_cnt_r == `DOPWM_LAST_PERIOD);

	// Prescaler divides the count clock by the count plus one
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST || !any_run) begin
			pre_cnt_r <= `DOPWM_RST_BYTE;
		end else if (pre_match) begin
			pre_cnt_r <= `DOPWM_RST_BYTE;
		end else if (cnt_clk) begin
			pre_cnt_r <= pre_cnt_r + 8'h01;
		end
	end

	// Fundamental counter steps once per prescaler period
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST || !any_run) begin
			fund_cnt_r <= `DOPWM_RST_BYTE;
		end else if (fund_match) begin
			fund_cnt_r <= `DOPWM_RST_BYTE;
		end else if (pre_match) begin
			fund_cnt_r <= fund_cnt_r + 8'h01;
		end
	end

	// Extra pulse counter is cleared by module reset only
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			add_cnt_r <= `DOPWM_RST_NIB;
		end else if (fund_match) begin
			add_cnt_r <= add_cnt_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output channels

	logic reload;
	logic pwm_a;
	logic pwm_b;

	// Buffers reload as the counter steps back to zero
	assign reload = fund_match;

	// Output A
	dopwm_chan u_chan_a (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.run(a_run_r),
		.reload(reload),
		.fund_cnt(fund_cnt_r),
		.add_cnt(add_cnt_r),
		.duty_high(a_duty_r),
		.extra(a_extra_r),
		.pwm(pwm_a)
	);

	// Output B
	dopwm_chan u_chan_b (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.run(b_run_r),
		.reload(reload),
		.fund_cnt(fund_cnt_r),
		.add_cnt(add_cnt_r),
		.duty_high(b_duty_r),
		.extra(b_extra_r),
		.pwm(pwm_b)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin drive

	function automatic dopwm_pin_mode_t pin_mode(input logic fa,
		input logic fb, input logic la, input logic dd);
		dopwm_pin_mode_t m;
		m = DOPWM_PIN_PORT;
		if (fa) begin
			unique case ({fb, la, dd})
				3'b010: m = DOPWM_PIN_INV;
				3'b001: m = DOPWM_PIN_CMOS;
				3'b110: m = DOPWM_PIN_SLOW;
				3'b101: m = DOPWM_PIN_OD;
				default: m = DOPWM_PIN_PORT;
			endcase
		end
		return m;
	endfunction : pin_mode

	dopwm_pin_mode_t mode_6;
	dopwm_pin_mode_t mode_7;

	assign mode_6 = pin_mode(fsa_r[`DOPWM_PIN_A], fsb_r[`DOPWM_PIN_A],
		lat_r[`DOPWM_PIN_A], ddr_r[`DOPWM_PIN_A]);
	assign mode_7 = pin_mode(fsa_r[`DOPWM_PIN_B], fsb_r[`DOPWM_PIN_B],
		lat_r[`DOPWM_PIN_B], ddr_r[`DOPWM_PIN_B]);

	// Pin 6; other combinations fall back to plain latch output
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PORT_PIN_6_OUT <= 1'b0;
			PORT_PIN_6_OE_N <= 1'b1;
			PORT_PIN_6_SLOW <= 1'b0;
		end else begin
			PORT_PIN_6_SLOW <= (mode_6 == DOPWM_PIN_SLOW);
			unique case (mode_6)
				DOPWM_PIN_INV: begin
					PORT_PIN_6_OUT <= !pwm_a;
					PORT_PIN_6_OE_N <= 1'b0;
				end
				DOPWM_PIN_CMOS, DOPWM_PIN_SLOW: begin
					PORT_PIN_6_OUT <= pwm_a;
					PORT_PIN_6_OE_N <= 1'b0;
				end
				DOPWM_PIN_OD: begin
					PORT_PIN_6_OUT <= 1'b0;
					PORT_PIN_6_OE_N <= pwm_a;
				end
				DOPWM_PIN_PORT: begin
					PORT_PIN_6_OUT <= lat_r[`DOPWM_PIN_A];
					PORT_PIN_6_OE_N <= !ddr_r[`DOPWM_PIN_A];
				end
			endcase
		end
	end

	// Pin 7 mirrors pin 6 for output B
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			PORT_PIN_7_OUT <= 1'b0;
			PORT_PIN_7_OE_N <= 1'b1;
			PORT_PIN_7_SLOW <= 1'b0;
		end else begin
			PORT_PIN_7_SLOW <= (mode_7 == DOPWM_PIN_SLOW);
			unique case (mode_7)
				DOPWM_PIN_INV: begin
					PORT_PIN_7_OUT <= !pwm_b;
					PORT_PIN_7_OE_N <= 1'b0;
				end
				DOPWM_PIN_CMOS, DOPWM_PIN_SLOW: begin
					PORT_PIN_7_OUT <= pwm_b;
					PORT_PIN_7_OE_N <= 1'b0;
				end
				DOPWM_PIN_OD: begin
					PORT_PIN_7_OUT <= 1'b0;
					PORT_PIN_7_OE_N <= pwm_b;
				end
				DOPWM_PIN_PORT: begin
					PORT_PIN_7_OUT <= lat_r[`DOPWM_PIN_B];
					PORT_PIN_7_OE_N <= !ddr_r[`DOPWM_PIN_B];
				end
			endcase
		end
	end

endmodule : dopwm_top

// ---- test/dopwm_chk.sv ----
// Port checks for the dual PWM unit, bound onto its top module
`timescale 1ns/1ps
`include "dopwm_consts.svh"

module dopwm_chk (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	// Register bus
	input wire logic [17:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [3:0] AVS_BYTEENABLE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [31:0] AVS_READDATA,
	input wire logic AVS_WAITREQUEST,
	// Pins and request
	input wire logic PORT_PIN_6_OE_N,
	input wire logic PORT_PIN_6_SLOW,
	input wire logic PORT_PIN_7_OE_N,
	input wire logic PORT_PIN_7_SLOW,
	input wire logic IRQ_REQ
);
	// One clock domain, so one clocking and one disable
	default clocking @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	////////////////////////////////////////
	// Bus handshake: one wait cycle, then re-armed
	a_read_answer: assert property ($rose(AVS_READ) |=> !AVS_WAITREQUEST)
		else $error("read not answered after one wait cycle");
	a_write_answer: assert property ($rose(AVS_WRITE) |=> !AVS_WAITREQUEST)
		else $error("write not answered after one wait cycle");
	a_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("wait request low for more than one cycle");
	a_wait_idle: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
		else $error("wait request dropped without a request");
	// Read data only moves after a read and carries one byte
	a_rdata_hold: assert property (!$past(AVS_READ) |-> $stable(AVS_READDATA))
		else $error("read data changed without a read");
	a_rdata_upper: assert property (AVS_READ |-> AVS_READDATA[31:8] == 24'h0)
		else $error("read data upper bits not zero");

	////////////////////////////////////////
	// Slow-edge drive only exists with the pin actively driven
	a_slow_pin_a: assert property (
		PORT_PIN_6_SLOW |-> !PORT_PIN_6_OE_N)
		else $error("pin 6 slow edge without drive");
	a_slow_pin_b: assert property (
		PORT_PIN_7_SLOW |-> !PORT_PIN_7_OE_N)
		else $error("pin 7 slow edge without drive");
	// Request gate is registered, so it falls two edges after enable clears
	a_irq_drop: assert property (
		AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && !AVS_WRITEDATA[0]
		&& AVS_ADDRESS[17:2] == `DOPWM_IDX_CTRL |-> ##2 !IRQ_REQ)
		else $error("interrupt request stays after enable cleared");
endmodule : dopwm_chk

bind dopwm_top dopwm_chk i_chk (
	.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WRITEDATA(AVS_WRITEDATA),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.PORT_PIN_6_OE_N(PORT_PIN_6_OE_N), .PORT_PIN_6_SLOW(PORT_PIN_6_SLOW),
	.PORT_PIN_7_OE_N(PORT_PIN_7_OE_N), .PORT_PIN_7_SLOW(PORT_PIN_7_SLOW),
	.IRQ_REQ(IRQ_REQ)
);

// ---- test/dopwm_load.sv ----
// External load on the two port pins, pull-up resistor on each
`timescale 1ns/1ps

module dopwm_load (
	// Pin drivers from the unit
	input wire logic out_6,
	input wire logic oe_n_6,
	input wire logic out_7,
	input wire logic oe_n_7,
	// Levels seen on the wires
	output logic lvl_6,
	output logic lvl_7
);
	// A released pin floats to the pull-up, so open drain reads high
	assign lvl_6 = oe_n_6 ? 1'b1 : out_6;
	assign lvl_7 = oe_n_7 ? 1'b1 : out_7;
endmodule : dopwm_load

// ---- test/tb_top.sv ----
// Self-checking bench for the dual PWM unit
`timescale 1ns/1ps
`include "dopwm_consts.svh"

module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic osc = 1'b0;
	logic [17:0] addr = 18'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wreq, irq, o6, e6, s6, o7, e7, s7, lv6, lv7;
	logic [7:0] q;
	int bad_count = 0;
	int n_compared = 0;
	int w, h, r;

	////////////////////////////////////////
	// System clock; oscillator at 8 cycles with a phase offset
	always #2.5 clk = ~clk;
	initial #1.3 forever #20 osc = ~osc;

	// Unit under test and the load on its pins
	dopwm_top i_dut (.SYS_CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(addr),
		.AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'h1),
		.AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
		.OSC_CLOCK(osc), .PORT_PIN_6_OUT(o6), .PORT_PIN_6_OE_N(e6),
		.PORT_PIN_6_SLOW(s6), .PORT_PIN_7_OUT(o7), .PORT_PIN_7_OE_N(e7),
		.PORT_PIN_7_SLOW(s7), .IRQ_REQ(irq));
	dopwm_load i_load (.out_6(o6), .oe_n_6(e6), .out_7(o7), .oe_n_7(e7),
		.lvl_6(lv6), .lvl_7(lv7));

	////////////////////////////////////////
	// Shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// One bus access, held until wait request is seen low
	task automatic bus(input logic we, input logic [15:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wr <= we;
		rd <= ~we;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 20);
		q = rdata[7:0];
		wr <= 1'b0;
		rd <= 1'b0;
		if (n >= 20) chk(32'h1, 32'h0);
	endtask : bus

	function automatic logic lvl(input logic sel);
		return sel ? lv7 : lv6;
	endfunction : lvl

	// Length of the next whole run at level pol; partial runs skipped
	task automatic meas(input logic sel, input logic pol, output int len);
		int n;
		n = 0;
		len = 0;
		repeat (4) @(posedge clk);
		while (lvl(sel) !== ~pol && n < 2000) begin
			@(posedge clk);
			n++;
		end
		while (lvl(sel) !== pol && n < 4000) begin
			@(posedge clk);
			n++;
		end
		while (lvl(sel) === pol && len < 2000) begin
			@(posedge clk);
			len++;
		end
	endtask : meas

	// High cycles and rising edges on pin 6 over a window
	task automatic win(input int ncyc, output int hi, output int ups);
		logic prev;
		hi = 0;
		ups = 0;
		prev = lv6;
		repeat (ncyc) begin
			@(posedge clk);
			if (lv6 === 1'b1) hi++;
			if (lv6 === 1'b1 && prev !== 1'b1) ups++;
			prev = lv6;
		end
	endtask : win

	////////////////////////////////////////
	// Reset values, access kinds and an unmapped place
	task automatic t_regs();
		logic [15:0] idx [6];
		idx = '{`DOPWM_IDX_A_EXTRA, `DOPWM_IDX_A_DUTY, `DOPWM_IDX_B_EXTRA,
			`DOPWM_IDX_B_DUTY, `DOPWM_IDX_PRESCALE, `DOPWM_IDX_TMCLK};
		foreach (idx[i]) begin
			bus(0, idx[i], 8'h00);
			chk(q, 32'h0);
			bus(1, idx[i], 8'hFF);
			bus(0, idx[i], 8'h00);
			chk(q, (i == 0 || i == 2) ? 8'hF0 : 8'hFF);
			bus(1, idx[i], 8'h00);
		end
		bus(1, 16'h7FB0, 8'hFF);
		bus(0, 16'h7FB0, 8'h00);
		chk(q, 32'h0);
	endtask : t_regs

	// All four drive kinds of pin 6, prescaler of two
	task automatic t_modes();
		logic [2:0] md [4];
		md = '{3'b010, 3'b001, 3'b110, 3'b101};
		bus(1, `DOPWM_IDX_PRESCALE, 8'h01);
		bus(1, `DOPWM_IDX_A_DUTY, 8'h03);
		bus(1, `DOPWM_IDX_PORT_FSA, 8'h40);
		bus(1, `DOPWM_IDX_CTRL, 8'h04);
		foreach (md[i]) begin
			bus(1, `DOPWM_IDX_PORT_FSB, {1'b0, md[i][2], 6'h0});
			bus(1, `DOPWM_IDX_PORT_LAT, {1'b0, md[i][1], 6'h0});
			bus(1, `DOPWM_IDX_PORT_DDR, {1'b0, md[i][0], 6'h0});
			meas(1'b0, md[i] != 3'b010, w);
			chk(w, 6);
			meas(1'b0, md[i] == 3'b010, w);
			chk(w, 26);
			chk(s6, md[i] == 3'b110);
		end
	endtask : t_modes

	// Output B alone, inverted, longer period; A held low meanwhile
	task automatic t_b();
		bus(1, `DOPWM_IDX_B_DUTY, 8'h05);
		bus(1, `DOPWM_IDX_PORT_FSA, 8'hC0);
		bus(1, `DOPWM_IDX_PORT_FSB, 8'h00);
		bus(1, `DOPWM_IDX_PORT_LAT, 8'h80);
		bus(1, `DOPWM_IDX_PORT_DDR, 8'h40);
		bus(1, `DOPWM_IDX_CTRL, 8'h18);
		bus(0, `DOPWM_IDX_CTRL, 8'h00);
		chk(q, 32'h18);
		meas(1'b1, 1'b0, w);
		chk(w, 10);
		meas(1'b1, 1'b1, w);
		chk(w, 54);
		win(64, h, r);
		chk(h, 0);
		chk(s7, 1'b0);
	endtask : t_b

	// Extra pulses over one whole overall period of 256 cycles
	task automatic t_extra();
		logic [3:0] nb [3];
		nb = '{4'h0, 4'h4, 4'hF};
		bus(1, `DOPWM_IDX_PRESCALE, 8'h00);
		bus(1, `DOPWM_IDX_A_DUTY, 8'h02);
		bus(1, `DOPWM_IDX_CTRL, 8'h04);
		foreach (nb[i]) begin
			bus(1, `DOPWM_IDX_A_EXTRA, {nb[i], 4'h0});
			repeat (20) @(posedge clk);
			win(256, h, r);
			chk(h, 32 + nb[i]);
			chk(r, 16);
		end
	endtask : t_extra

	// Clock source switched only while both outputs are stopped
	task automatic t_osc();
		bus(1, `DOPWM_IDX_CTRL, 8'h00);
		bus(1, `DOPWM_IDX_TMCLK, 8'hFF);
		bus(1, `DOPWM_IDX_A_EXTRA, 8'h00);
		bus(1, `DOPWM_IDX_CTRL, 8'h04);
		meas(1'b0, 1'b1, w);
		chk(w, 16);
		bus(1, `DOPWM_IDX_CTRL, 8'h00);
		bus(1, `DOPWM_IDX_TMCLK, 8'hFE);
		bus(1, `DOPWM_IDX_CTRL, 8'h04);
		meas(1'b0, 1'b1, w);
		chk(w, 2);
	endtask : t_osc

	// Overflow flag, gated request and clearing by software
	task automatic t_irq();
		int n;
		n = 0;
		bus(1, `DOPWM_IDX_CTRL, 8'h05);
		while (irq !== 1'b1 && n < 600) begin
			@(posedge clk);
			n++;
		end
		chk(irq, 1'b1);
		bus(0, `DOPWM_IDX_CTRL, 8'h00);
		chk(q, 8'h07);
		bus(1, `DOPWM_IDX_CTRL, 8'h00);
		repeat (3) @(posedge clk);
		chk(irq, 1'b0);
		bus(0, `DOPWM_IDX_CTRL, 8'h00);
		chk(q, 8'h00);
	endtask : t_irq

	////////////////////////////////////////
	// Verdict, reached from the sequence or the watchdog
	task automatic test_done();
		$display("compared=%0d mismatches=%0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	// Main sequence after two cycles of reset
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_modes();
		t_b();
		t_extra();
		t_osc();
		t_irq();
		test_done();
	end

	// Whole run needs well under 10k cycles; cut a hang at 40k
	initial begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule : tb_top
